//--- host_sink.sv
// serial host model taking result record bytes with random stalls
`timescale 1ns/1ps
module host_sink (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // record stream
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // accepted bytes
  output logic            rxValid,
  output logic [7:0]      rxByte
);
  int stallCnt;

  initial begin
    txReady = 1'b0;
    rxValid = 1'b0;
    rxByte = 8'h00;
    stallCnt = 0;
  end

  // long stalls now and then, so the buffer really fills up
  always @(posedge ref_clk) begin
    rxValid <= txValid && txReady && !rst;
    rxByte <= txData;
    #1;
    if (stallCnt > 0) stallCnt--;
    else if ($urandom_range(15) == 0) stallCnt = 12;
    txReady = (stallCnt == 0) && ($urandom_range(3) != 0);
  end
endmodule

//--- rec_skid_buffer.sv
// two-entry valid/ready buffer in the record byte path
`timescale 1ns/1ps
module rec_skid_buffer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);

  typedef struct packed {
    logic         mainV;
    logic [W-1:0] main;
    logic         skidV;
    logic [W-1:0] skid;
  } buf_t;

  buf_t s_r;
  buf_t s_nxt;

  // =====================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    if (s_r.mainV == 1'b0 || outReady) begin
      // skid drains first so words stay in order
      if (s_r.skidV) begin
        s_nxt.main  = s_r.skid;
        s_nxt.mainV = 1'b1;
        s_nxt.skidV = 1'b0;
      end else begin
        s_nxt.main  = inData;
        s_nxt.mainV = inValid;
      end
    end else if (inValid && !s_r.skidV) begin
      s_nxt.skid  = inData;
      s_nxt.skidV = 1'b1;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ready is a flop: full only when the skid holds a word
  assign inReady  = ~s_r.skidV;
  assign outValid = s_r.mainV;
  assign outData  = s_r.main;

endmodule

//--- result_fmt_asserts.sv
// concurrent checks on the result matcher and formatter ports
`timescale 1ns/1ps
module result_fmt_asserts
  import result_fmt_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // decode event and configuration
  input wire logic       decodeDone,
  input wire logic       readOk,
  input wire logic [1:0] readMode,
  input wire logic       addDecCnt,
  input wire logic       trigger,
  // results
  input wire logic       okOut,
  input wire logic       ngOut,
  input wire logic       busy,
  // record stream
  input wire logic       txValid,
  input wire logic [7:0] txData,
  input wire logic       txReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // =========
  // helper: trigger held high since the decode was taken
  logic trigHeld_r;
  always_ff @(posedge ref_clk) begin
    trigHeld_r <= !rst && trigger && (trigHeld_r || (decodeDone && !busy));
  end

  // =========
  // properties
  a_rst_quiet: assert property (disable iff (1'b0)
    rst |=> !okOut && !ngOut && !busy && !txValid) else $error("outputs not idle after reset");
  a_ok_ng_excl: assert property (!(okOut && ngOut))
    else $error("ok and ng both high");
  a_busy_take: assert property (decodeDone && !busy |=> busy)
    else $error("decode not taken");
  a_busy_cause: assert property ($rose(busy) |-> $past(decodeDone))
    else $error("busy without decode");
  a_res_steady: assert property (!busy && !$past(busy) && !$past(decodeDone)
    |-> $stable({okOut, ngOut})) else $error("result moved while idle");
  a_fail_ng: assert property (decodeDone && !busy && !readOk
    |-> ##[1:3] (ngOut && !okOut)) else $error("failed read not ng");
  a_multi_ok: assert property (decodeDone && !busy && readOk && readMode != MODE_SINGLE
    |-> ##[1:3] (okOut && !ngOut)) else $error("multi mode read not ok");
  a_trig_wait: assert property (trigHeld_r && busy && !txValid && addDecCnt
    && readMode == MODE_SINGLE |=> !txValid) else $error("record sent while trigger on");
  a_tx_stall: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("record byte lost in stall");

  c_stall: cover property ((txValid && !txReady) [*3]);
  c_fail: cover property (decodeDone && !busy && !readOk);
  c_done_ok: cover property ($fell(busy) && okOut);
endmodule

bind result_matcher_formatter result_fmt_asserts u_chk (
  .ref_clk(ref_clk), .rst(rst), .decodeDone(decodeDone), .readOk(readOk),
  .readMode(readMode), .addDecCnt(addDecCnt), .trigger(trigger), .okOut(okOut),
  .ngOut(ngOut), .busy(busy), .txValid(txValid), .txData(txData), .txReady(txReady)
);

//--- result_fmt_pkg.sv
// shared constants and types for the bar code result matcher and formatter
package result_fmt_pkg;

  // =====================================================================
  // read modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_MULTI1 = 2'h1;
  localparam logic [1:0] MODE_MULTI2 = 2'h2;
  localparam logic [1:0] MODE_MULTI3 = 2'h3;

  // =====================================================================
  // pattern and record characters
  localparam logic [7:0] CHR_VARLEN   = 8'h21;  // matches any run
  localparam logic [7:0] CHR_ONE      = 8'h3F;  // matches one char
  localparam logic [7:0] CHR_SCAN_DLM = 8'h3A;  // fixed, before scan count
  localparam logic [7:0] CHR_TERM     = 8'h0D;
  localparam logic [7:0] CHR_ZERO     = 8'h30;
  localparam logic [7:0] CHR_FWD      = 8'h46;
  localparam logic [7:0] CHR_REV      = 8'h52;
  localparam logic [2:0] TYPE_RD_ERR  = 3'h7;

  // =====================================================================
  // counts and timing
  localparam logic [13:0] COUNT_MAX     = 14'h270F;  // 9999
  localparam int          CLK_PERIOD_NS = 32'h0000_0064;  // 100 ns
  localparam int          MS_NS         = 32'h000F_4240;  // 1 ms
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // =====================================================================
  // states and record fields
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_MATCH = 3'h1,
    S_HOLD  = 3'h3,
    S_EMIT  = 3'h2
  } state_t;

  typedef enum logic [2:0] {
    F_TYPE   = 3'h0,
    F_ORIENT = 3'h1,
    F_DATA   = 3'h2,
    F_DCNT   = 3'h3,
    F_SCNT   = 3'h4,
    F_TERM   = 3'h5
  } field_t;

endpackage

//--- result_matcher_formatter.sv
// preset matching, ok/ng result and result record formatting
`timescale 1ns/1ps
// Operation
// - one stored pattern; each decoded label compared, ok on match, ng otherwise
// - empty pattern acts as lone variable wildcard: ok on success, ng on failure
// - pattern comparison only in single-label mode, never in multi-label modes
// - one-char wildcard matches any single char; no run wildcard means equal length
// - run wildcard matches zero or more chars: prefix, suffix or both
// - asterisk is compared literally, never a wildcard
// - comparison uses the whole label, not the designated span
// - decode count appended, zero-suppressed, saturates 9999, floor is match count
// - decode count in single mode: record sent after trigger drops
// - decode count in multi 1: sent after beam clear plus repeat time
// - decode count in multi 2 or 3 leaves output timing unchanged
// - scan count after decode count, counts empty scans, saturates 9999
// - code type prefix is one digit, 7 meaning read error
// - orientation field before data, omitted on a failed read
// - order type, orientation, data, decode, scan; delimiters between present fields
// - delimiter is configurable, scan count delimiter is fixed
// - designated span: direction, start digit and count per code slot 1 to 4
// - reverse direction counts start from last char toward the label start
// - extracted chars always sent in original left-to-right order
module result_matcher_formatter
  import result_fmt_pkg::*;
#(
  parameter int DEPTH   = 64,
  parameter int AW      = 6,
  parameter int MS_CYC  = MS_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // label and pattern loading
  input  wire logic        lblWe,
  input  wire logic [AW-1:0] lblAddr,
  input  wire logic [7:0]  lblData,
  input  wire logic        presetWe,
  input  wire logic [AW-1:0] presetAddr,
  input  wire logic [7:0]  presetData,
  input  wire logic [7:0]  presetLen,
  // decode event
  input  wire logic        decodeDone,
  input  wire logic        readOk,
  input  wire logic [2:0]  codeType,
  input  wire logic        orientRev,
  input  wire logic [1:0]  codeSlot,
  input  wire logic [7:0]  lblLen,
  // scan activity
  input  wire logic        decodePulse,
  input  wire logic        scanPulse,
  input  wire logic        beamLeft,
  input  wire logic        trigger,
  // configuration
  input  wire logic [1:0]  readMode,
  input  wire logic        sendAfterRead,
  input  wire logic        addType,
  input  wire logic        addOrient,
  input  wire logic        addDecCnt,
  input  wire logic        addScanCnt,
  input  wire logic [7:0]  delimChar,
  input  wire logic [7:0]  matchCount,
  input  wire logic [7:0]  repeatMs,
  input  wire logic [63:0] errStr,
  input  wire logic [3:0]  errLen,
  input  wire logic [3:0]  digEn,
  input  wire logic [3:0]  digRev,
  input  wire logic [31:0] digStart,
  input  wire logic [31:0] digCount,
  // results
  output logic             okOut,
  output logic             ngOut,
  output logic             busy,
  // record byte stream
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady
);

  typedef struct packed {
    state_t      st;
    field_t      field;
    logic        mismatch;
    logic        afterBang;
    logic [7:0]  idx;
    logic        ok;
    logic        ng;
    logic        rdOk;
    logic [2:0]  ctype;
    logic        orient;
    logic [1:0]  slot;
    logic [7:0]  len;
    logic [13:0] decCnt;
    logic [13:0] scanCnt;
    logic        needDelim;
    logic        delimSent;
    logic        seenNz;
    logic [7:0]  sub;
    logic [15:0] msCnt;
    logic [7:0]  repCnt;
    logic        beamSeen;
    logic        run;
  } ctl_t;

  ctl_t s_r;
  ctl_t s_nxt;

  logic [7:0] lblMem [DEPTH];
  logic [7:0] patMem [DEPTH];

  logic       push;
  logic [7:0] pushByte;
  logic       bufReady;

  // =====================================================================
  // helpers
  function automatic logic [15:0] toBcd(input logic [13:0] v);
    logic [15:0] b;
    b = 16'h0000;
    for (int i = 13; i >= 0; i--) begin
      for (int d = 0; d < 4; d++) begin
        if (b[d*4 +: 4] > 4'h4) begin
          b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
        end
      end
      b = {b[14:0], v[i]};
    end
    return b;
  endfunction

  function automatic logic [13:0] incSat(input logic [13:0] v);
    return (v < COUNT_MAX) ? v + 14'h0001 : v;
  endfunction

  // =====================================================================
  // label and pattern storage
  always_ff @(posedge ref_clk) begin
    if (lblWe) begin
      lblMem[lblAddr] <= lblData;
    end
    if (presetWe) begin
      patMem[presetAddr] <= presetData;
    end
  end

  // =====================================================================
  // designated span, counted in 9 bits to avoid wrap
  logic [8:0]  spanStart;
  logic [8:0]  spanCnt;
  logic [8:0]  spanLen;
  logic [8:0]  dataLo;
  logic [8:0]  dataHi;
  logic [13:0] decShown;
  logic [15:0] bcdDec;
  logic [15:0] bcdScan;
  logic [3:0]  digit;

  always_comb begin
    spanStart = {1'b0, digStart[s_r.slot*8 +: 8]};
    spanCnt   = {1'b0, digCount[s_r.slot*8 +: 8]};
    spanLen   = {1'b0, s_r.len};
    if (spanStart == 9'h000) begin
      spanStart = 9'h001;
    end
    dataLo = 9'h000;
    dataHi = spanLen;
    if (!s_r.rdOk) begin
      dataHi = {5'h00, errLen};
    end else if (digEn[s_r.slot]) begin
      if (!digRev[s_r.slot]) begin
        dataLo = spanStart - 9'h001;
        dataHi = dataLo + spanCnt;
        if (dataHi > spanLen) begin
          dataHi = spanLen;
        end
      end else if (spanStart > spanLen) begin
        dataHi = 9'h000;
      end else begin
        dataHi = spanLen - spanStart + 9'h001;
        dataLo = (dataHi > spanCnt) ? dataHi - spanCnt : 9'h000;
      end
    end
    decShown = (s_r.decCnt < {6'h00, matchCount}) ? {6'h00, matchCount} : s_r.decCnt;
    bcdDec   = toBcd(decShown);
    bcdScan  = toBcd(s_r.scanCnt);
    digit    = (s_r.field == F_DCNT) ? bcdDec[s_r.sub[1:0]*4 +: 4]
                                     : bcdScan[s_r.sub[1:0]*4 +: 4];
  end

  // =====================================================================
  // control
  logic       fieldOn;
  logic       sendGo;
  logic [7:0] pc;
  logic [7:0] li;

  always_comb begin
    s_nxt    = s_r;
    push     = 1'b0;
    pushByte = 8'h00;
    fieldOn  = 1'b0;
    sendGo   = 1'b0;
    pc       = patMem[s_r.idx[AW-1:0]];
    li       = s_r.afterBang ? s_r.len - presetLen + s_r.idx : s_r.idx;

    // free running millisecond enable
    s_nxt.msCnt = (s_r.msCnt == 16'(MS_CYC - 1)) ? 16'h0000 : s_r.msCnt + 16'h0001;

    if (decodePulse) begin
      s_nxt.decCnt = incSat(s_r.decCnt);
    end
    if (scanPulse) begin
      s_nxt.scanCnt = incSat(s_r.scanCnt);
    end

    case (s_r.st)
      S_IDLE: begin
        if (decodeDone) begin
          s_nxt.rdOk      = readOk;
          s_nxt.ctype     = codeType;
          s_nxt.orient    = orientRev;
          s_nxt.slot      = codeSlot;
          s_nxt.len       = lblLen;
          s_nxt.idx       = 8'h00;
          s_nxt.mismatch  = 1'b0;
          s_nxt.afterBang = 1'b0;
          s_nxt.beamSeen  = 1'b0;
          s_nxt.repCnt    = 8'h00;
          if (readOk && readMode == MODE_SINGLE) begin
            s_nxt.st = S_MATCH;
          end else begin
            s_nxt.ok = readOk;
            s_nxt.ng = ~readOk;
            s_nxt.st = S_HOLD;
          end
        end
      end
      S_MATCH: begin
        if (s_r.idx >= presetLen) begin
          // no run wildcard needs equal length
          if (presetLen != 8'h00 && !s_r.afterBang && s_r.len != presetLen) begin
            s_nxt.mismatch = 1'b1;
          end
          s_nxt.ok = ~s_nxt.mismatch;
          s_nxt.ng = s_nxt.mismatch;
          s_nxt.st = S_HOLD;
        end else begin
          if (pc == CHR_VARLEN) begin
            s_nxt.afterBang = 1'b1;
            if ({1'b0, s_r.len} + 9'h001 < {1'b0, presetLen}) begin
              s_nxt.mismatch = 1'b1;
            end
          end else if (!s_r.afterBang && s_r.idx >= s_r.len) begin
            s_nxt.mismatch = 1'b1;
          end else if (pc != CHR_ONE && pc != lblMem[li[AW-1:0]]) begin
            s_nxt.mismatch = 1'b1;
          end
          s_nxt.idx = s_r.idx + 8'h01;
        end
      end
      S_HOLD: begin
        if (addDecCnt && readMode == MODE_SINGLE) begin
          sendGo = ~trigger;
        end else if (addDecCnt && readMode == MODE_MULTI1) begin
          if (beamLeft) begin
            s_nxt.beamSeen = 1'b1;
          end
          if (s_r.beamSeen && s_r.msCnt == 16'h0000) begin
            s_nxt.repCnt = s_r.repCnt + 8'h01;
          end
          sendGo = s_r.beamSeen && s_r.repCnt >= repeatMs;
        end else if (readMode == MODE_SINGLE) begin
          sendGo = sendAfterRead | ~trigger;
        end else begin
          sendGo = 1'b1;
        end
        if (sendGo) begin
          s_nxt.st        = S_EMIT;
          s_nxt.field     = F_TYPE;
          s_nxt.needDelim = 1'b0;
          s_nxt.delimSent = 1'b0;
          s_nxt.seenNz    = 1'b0;
        end
      end
      S_EMIT: begin
        case (s_r.field)
          F_TYPE:   fieldOn = addType;
          F_ORIENT: fieldOn = addOrient & s_r.rdOk;  // omit on failure
          F_DATA:   fieldOn = 1'b1;
          F_DCNT:   fieldOn = addDecCnt;
          F_SCNT:   fieldOn = addDecCnt & addScanCnt;
          default:  fieldOn = 1'b1;
        endcase
        // stalls here while the buffer is full
        if (!bufReady) begin
          fieldOn = fieldOn;
        end else if (!fieldOn) begin
          s_nxt.field = field_t'(s_r.field + 3'h1);
          s_nxt.sub   = (s_r.field == F_ORIENT) ? dataLo[7:0] : 8'h03;
        end else if (s_r.needDelim && !s_r.delimSent && s_r.field != F_TERM) begin
          push            = 1'b1;
          pushByte        = (s_r.field == F_SCNT) ? CHR_SCAN_DLM : delimChar;
          s_nxt.delimSent = 1'b1;
        end else begin
          s_nxt.delimSent = s_r.delimSent;
          case (s_r.field)
            F_TYPE: begin
              push     = 1'b1;
              pushByte = CHR_ZERO + {5'h00, (s_r.rdOk ? s_r.ctype : TYPE_RD_ERR)};
            end
            F_ORIENT: begin
              push     = 1'b1;
              pushByte = s_r.orient ? CHR_REV : CHR_FWD;
            end
            F_DATA: begin
              if ({1'b0, s_r.sub} < dataHi) begin
                push      = 1'b1;
                pushByte  = s_r.rdOk ? lblMem[s_r.sub[AW-1:0]] : errStr[s_r.sub[2:0]*8 +: 8];
                s_nxt.sub = s_r.sub + 8'h01;
              end
            end
            F_DCNT, F_SCNT: begin
              if (s_r.sub == 8'h00 || digit != 4'h0 || s_r.seenNz) begin
                push         = 1'b1;
                pushByte     = CHR_ZERO + {4'h0, digit};
                s_nxt.seenNz = 1'b1;
              end
              s_nxt.sub = s_r.sub - 8'h01;
            end
            default: begin
              push            = 1'b1;
              pushByte        = CHR_TERM;
              s_nxt.st        = S_IDLE;
              // a pulse in the clearing cycle still counts toward the next record
              s_nxt.decCnt    = decodePulse ? 14'h0001 : 14'h0000;
              s_nxt.scanCnt   = scanPulse ? 14'h0001 : 14'h0000;
            end
          endcase
          // field finished: move on and arm the delimiter
          if (s_r.field == F_TYPE || s_r.field == F_ORIENT || (s_r.field == F_DATA &&
              {1'b0, s_r.sub} >= dataHi) || ((s_r.field == F_DCNT ||
              s_r.field == F_SCNT) && s_r.sub == 8'h00)) begin
            s_nxt.field     = field_t'(s_r.field + 3'h1);
            s_nxt.sub       = (s_r.field == F_ORIENT) ? dataLo[7:0] : 8'h03;
            s_nxt.needDelim = 1'b1;
            s_nxt.delimSent = 1'b0;
            s_nxt.seenNz    = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
    // type field skipped from hold: data start must still be set
    if (s_r.st == S_HOLD && sendGo) begin
      s_nxt.sub = dataLo[7:0];
    end
    // busy kept in a flop so the port has no decode behind it
    s_nxt.run = (s_nxt.st != S_IDLE);
  end

  // =====================================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign okOut = s_r.ok;
  assign ngOut = s_r.ng;
  assign busy  = s_r.run;

  // =====================================================================
  // output buffer; its ready stalls the formatter
  rec_skid_buffer #(
    .W(8)
  ) u_buf (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (push),
    .inData   (pushByte),
    .inReady  (bufReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txReady)
  );

endmodule

//--- testbench.sv
// self-checking bench for the result matcher and formatter
`timescale 1ns/1ps
module testbench;
  import result_fmt_pkg::*;
  logic        ref_clk, rst, lblWe, presetWe, decodeDone, readOk, orientRev;
  logic        decodePulse, scanPulse, beamLeft, trigger, sendAfterRead, busyD;
  logic        addType, addOrient, addDecCnt, addScanCnt, txValid, txReady;
  logic        okOut, ngOut, busy, rxValid;
  logic [5:0]  lblAddr, presetAddr;
  logic [7:0]  lblData, presetData, presetLen, lblLen, delimChar, matchCount;
  logic [7:0]  repeatMs, txData, rxByte;
  logic [2:0]  codeType;
  logic [1:0]  codeSlot, readMode;
  logic [63:0] errStr;
  logic [3:0]  errLen, digEn, digRev;
  logic [31:0] digStart, digCount;
  logic [7:0]  expB[$];
  logic [1:0]  expR[$];
  int          failures, comparisons;
  string pt[10] = '{"ABC?", "ABC?", "ABC!", "ABC!", "!CDE", "!CDE", "A!E", "A!E", "A*C", "A*C"};
  string lb[10] = '{"ABCD", "ABC", "ABC", "AB", "3CDE", "ABBDE", "AE", "ABCD", "ABC", "A*C"};
  string dl[4] = '{"49123456", "158423421", "49123456", "58423421"};
  string ds[4] = '{"1234", "34", "56", "34"};
  localparam logic [9:0] OKV = 10'h255;

  result_matcher_formatter #(.MS_CYC(10)) dut (
    .ref_clk(ref_clk), .rst(rst), .lblWe(lblWe), .lblAddr(lblAddr), .lblData(lblData),
    .presetWe(presetWe), .presetAddr(presetAddr), .presetData(presetData),
    .presetLen(presetLen), .decodeDone(decodeDone), .readOk(readOk), .codeType(codeType),
    .orientRev(orientRev), .codeSlot(codeSlot), .lblLen(lblLen), .decodePulse(decodePulse),
    .scanPulse(scanPulse), .beamLeft(beamLeft), .trigger(trigger), .readMode(readMode),
    .sendAfterRead(sendAfterRead), .addType(addType), .addOrient(addOrient),
    .addDecCnt(addDecCnt), .addScanCnt(addScanCnt), .delimChar(delimChar),
    .matchCount(matchCount), .repeatMs(repeatMs), .errStr(errStr), .errLen(errLen),
    .digEn(digEn), .digRev(digRev), .digStart(digStart), .digCount(digCount),
    .okOut(okOut), .ngOut(ngOut), .busy(busy), .txValid(txValid), .txData(txData),
    .txReady(txReady));
  host_sink host (.ref_clk(ref_clk), .rst(rst), .txValid(txValid), .txData(txData),
    .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // =========
  // tasks
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk8(logic [7:0] e, logic [7:0] a);
    comparisons++;
    if (a !== e) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic chkR(logic [1:0] e, logic [1:0] a);
    comparisons++;
    if (a !== e) begin
      failures++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic put(string s);
    foreach (s[i]) expB.push_back(s[i]);
  endtask
  function automatic int sat(int v);
    return (v > int'(COUNT_MAX)) ? int'(COUNT_MAX) : v;
  endfunction
  task automatic load(string p, string l);
    int len;
    len = (p.len() > l.len()) ? p.len() : l.len();
    for (int i = 0; i < len; i++) begin
      lblWe = (i < l.len());
      presetWe = (i < p.len());
      lblAddr = i[5:0];
      presetAddr = i[5:0];
      lblData = l[i];
      presetData = p[i];
      tick(1);
    end
    {lblWe, presetWe} = 2'h0;
    presetLen = 8'(p.len());
    lblLen = 8'(l.len());
  endtask
  task automatic fire(logic rd, logic [1:0] r);
    expR.push_back(r);
    readOk = rd;
    decodeDone = 1'b1;
    tick(1);
    decodeDone = 1'b0;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while ((busy !== 1'b0 || expB.size() != 0) && n < 32'h0000_4E20) begin
      tick(1);
      n++;
    end
    if (n == 32'h0000_4E20) failures++;
    tick(2);
  endtask
  task automatic pulses(int n, int m);
    for (int k = 0; k < m; k++) begin
      decodePulse = (k < n);
      scanPulse = 1'b1;
      tick(1);
    end
    {decodePulse, scanPulse} = 2'h0;
  endtask
  task automatic end_sim();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // =========
  // result watcher: bytes at the host, ok/ng when a record completes
  always @(negedge ref_clk) begin
    if (!rst && rxValid) chk8(expB.pop_front(), rxByte);
    if (!rst && busyD === 1'b1 && busy === 1'b0) chkR(expR.pop_front(), {okOut, ngOut});
    busyD = busy;
  end

  initial begin
    repeat (32'h0000_EA60) @(posedge ref_clk);
    failures++;
    end_sim();
  end

  // =========
  // main sequence
  initial begin
    int n;
    int m;
    rst = 1'b1;
    {lblWe, presetWe, decodeDone, readOk, orientRev, decodePulse, scanPulse, beamLeft} = 8'h00;
    {trigger, addType, addOrient, addDecCnt, addScanCnt} = 5'h00;
    {lblAddr, presetAddr, lblData, presetData, presetLen, lblLen} = 44'h000_0000_0000;
    {sendAfterRead, readMode, codeType, codeSlot} = 8'h80;
    {delimChar, matchCount, repeatMs} = 24'h2C_0102;
    {errStr, errLen} = 68'h0000_0000_0052_5245_3;
    {digEn, digRev, digStart, digCount} = 72'h00_0000_0000_0000_0000;
    failures = 0;
    comparisons = 0;
    void'($urandom(32'hA081_C4C9));
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    foreach (pt[i]) begin
      load(pt[i], lb[i]);
      put({lb[i], "\r"});
      fire(1'b1, OKV[i] ? 2'h2 : 2'h1);
      waitIdle();
    end
    load("", "XYZ");
    put("XYZ\r");
    fire(1'b1, 2'h2);
    waitIdle();
    {addType, addOrient} = 2'h3;
    put("7,ERR\r");
    fire(1'b0, 2'h1);
    waitIdle();
    // all fields, sent on trigger release
    {addDecCnt, addScanCnt, matchCount} = 10'h305;
    load("!", "AB12");
    for (int t = 0; t < 7; t++) begin
      n = (t == 6) ? 32'h0000_2712 : $urandom_range(12);
      m = n + ((t == 6) ? 0 : $urandom_range(4));
      pulses(n, m);
      codeType = t[2:0];
      orientRev = t[0];
      put($sformatf("%0d,%s,AB12,", t, t[0] ? "R" : "F"));
      put($sformatf("%0d:%0d\r", sat((n < 5) ? 5 : n), sat(m)));
      trigger = 1'b1;
      fire(1'b1, 2'h2);
      tick(20);
      chkR(2'h0, {1'b0, txValid});
      trigger = 1'b0;
      waitIdle();
    end
    {addType, addOrient, addScanCnt, matchCount} = 11'h001;
    load("ZZZ", "AB");
    readMode = MODE_MULTI1;
    put("AB,1\r");
    fire(1'b1, 2'h2);
    tick(30);
    chkR(2'h0, {1'b0, txValid});
    beamLeft = 1'b1;
    tick(1);
    beamLeft = 1'b0;
    tick(5);
    chkR(2'h0, {1'b0, txValid});
    waitIdle();
    for (int md = 2; md < 4; md++) begin
      readMode = md[1:0];
      trigger = 1'b1;
      put("AB,1\r");
      fire(1'b1, 2'h2);
      waitIdle();
      trigger = 1'b0;
    end
    {readMode, addDecCnt} = 3'h0;
    {digEn, digRev, digStart, digCount} = 72'hFA_0307_0303_0205_0204;
    sendAfterRead = 1'b0;
    for (int s = 0; s < 4; s++) begin
      load("4912!", dl[s]);
      codeSlot = s[1:0];
      put({ds[s], "\r"});
      trigger = 1'b1;
      fire(1'b1, s[0] ? 2'h1 : 2'h2);
      tick(12);
      chkR(2'h0, {1'b0, txValid});
      trigger = 1'b0;
      waitIdle();
    end
    end_sim();
  end
endmodule
